// *** src/ssiar_top.sv ***
`timescale 1ns/1ps
`include "ssiar_defs.svh"

module ssiar_top #(
	parameter int TIMEOUT_CYC = `SSIAR_TIMEOUT_CYC,
	parameter logic [`SSIAR_CRC_W-1:0] CRC_POLY = `SSIAR_CRC_POLY_RST,
	parameter bit ANGLE_INVERT = 1'h0
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic SSI_CLK,
	input wire logic [`SSIAR_ANGLE_W-1:0] ANGLE,
	output logic SSI_DATA,
	output logic FRAME_ACTIVE
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [`SSIAR_CRC_W-1:0] crc_calc(input logic [`SSIAR_ANGLE_W+`SSIAR_RSV_W-1:0] d);
		logic [`SSIAR_CRC_W-1:0] c;
		logic fb;
		c = `SSIAR_CRC_INIT;
		for (int i = `SSIAR_ANGLE_W + `SSIAR_RSV_W - 1; i >= 0; i--) begin
			fb = c[`SSIAR_CRC_W-1] ^ d[i];
			c = {c[`SSIAR_CRC_W-2:0], 1'h0};
			if (fb) begin
				c = c ^ CRC_POLY;
			end
		end
		return c;
	endfunction

	localparam logic [4:0] LAST_BIT = 5'(`SSIAR_FRAME_W - 1);
	// cut frame count: header, angle, plus the rise that returns the clock high
	localparam logic [4:0] SHORT_END = 5'(`SSIAR_HDR_W + `SSIAR_ANGLE_W + 1);
	localparam logic [8:0] TMO_LAST = 9'(TIMEOUT_CYC - 1);

	// ----------------------------------------
	// link clock synchroniser and edge finder
	// ----------------------------------------
	logic clk_s1_reg;
	logic clk_s2_reg;
	logic clk_s3_reg;
	logic clk_rise;
	logic clk_fall;
	logic clk_edge;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			clk_s1_reg <= 1'h1;
			clk_s2_reg <= 1'h1;
			clk_s3_reg <= 1'h1;
		end else begin
			clk_s1_reg <= SSI_CLK;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
		end
	end

	assign clk_rise = clk_s2_reg & ~clk_s3_reg;
	assign clk_fall = ~clk_s2_reg & clk_s3_reg;
	assign clk_edge = clk_rise | clk_fall;

	// ----------------------------------------
	// frame assembly
	// ----------------------------------------
	logic [`SSIAR_ANGLE_W-1:0] angle_rep;
	logic [`SSIAR_FRAME_W-1:0] frame_word;
	logic [`SSIAR_FRAME_W-1:0] frame_reg;

	// sensor counts up clockwise; invert for mirrored mounting
	assign angle_rep = ANGLE_INVERT ? ~ANGLE : ANGLE;

	always_comb begin
		frame_word = '0;
		frame_word[`SSIAR_HDR_POS +: `SSIAR_HDR_W] = `SSIAR_HDR_VAL;
		frame_word[`SSIAR_ANGLE_POS +: `SSIAR_ANGLE_W] = angle_rep;
		frame_word[`SSIAR_RSV_POS +: `SSIAR_RSV_W] = `SSIAR_RSV_VAL;
		frame_word[`SSIAR_CRC_POS +: `SSIAR_CRC_W] = crc_calc({angle_rep, `SSIAR_RSV_VAL});
	end

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	ssiar_pkg::ssiar_state_t state_reg;
	ssiar_pkg::ssiar_state_t state_next;
	logic [4:0] bit_cnt_reg;
	logic [8:0] tmo_cnt_reg;
	logic start_frame;
	logic timeout;

	// first falling edge in idle freezes the angle
	assign start_frame = (state_reg == ssiar_pkg::SSIAR_IDLE) && clk_fall;
	assign timeout = (state_reg != ssiar_pkg::SSIAR_IDLE) && !clk_edge && (tmo_cnt_reg == TMO_LAST);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ssiar_pkg::SSIAR_IDLE: begin
				if (start_frame) begin
					state_next = ssiar_pkg::SSIAR_SHIFT;
				end
			end
			ssiar_pkg::SSIAR_SHIFT: begin
				if (timeout) begin
					state_next = ssiar_pkg::SSIAR_IDLE;
				end else if (clk_rise && bit_cnt_reg == LAST_BIT) begin
					state_next = ssiar_pkg::SSIAR_WAIT;
				end
			end
			ssiar_pkg::SSIAR_WAIT: begin
				if (timeout) begin
					state_next = ssiar_pkg::SSIAR_IDLE;
				end
			end
			default: begin
				state_next = ssiar_pkg::SSIAR_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= ssiar_pkg::SSIAR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			FRAME_ACTIVE <= 1'h0;
		end else begin
			FRAME_ACTIVE <= state_next != ssiar_pkg::SSIAR_IDLE;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			frame_reg <= '0;
		end else if (start_frame) begin
			frame_reg <= frame_word;
		end
	end

	// one bit per rising edge of the link clock
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bit_cnt_reg <= 5'h00;
		end else if (start_frame) begin
			bit_cnt_reg <= 5'h00;
		end else if (state_reg == ssiar_pkg::SSIAR_SHIFT && clk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// idle timer, restarted by every link clock edge
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tmo_cnt_reg <= 9'h000;
		end else if (state_reg == ssiar_pkg::SSIAR_IDLE || clk_edge || timeout) begin
			tmo_cnt_reg <= 9'h000;
		end else begin
			tmo_cnt_reg <= tmo_cnt_reg + 9'h001;
		end
	end

	// ----------------------------------------
	// data line
	// ----------------------------------------
	ssiar_shift #(
		.WIDTH(`SSIAR_FRAME_W)
	) u_shift (
		.clk(CORE_CLK),
		.rst(RST),
		.load(start_frame),
		.word(frame_word),
		.shift(state_reg != ssiar_pkg::SSIAR_IDLE && clk_rise && !timeout),
		.clear(timeout),
		.dout(SSI_DATA)
	);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_link_start;
		@(posedge CORE_CLK) disable iff (RST)
		start_frame |=> FRAME_ACTIVE && state_reg == ssiar_pkg::SSIAR_SHIFT;
	endproperty
	a_link_start: assert property (p_link_start) else $error("frame did not open on clock fall");

	property p_bit_out;
		@(posedge CORE_CLK) disable iff (RST)
		(state_reg == ssiar_pkg::SSIAR_SHIFT && clk_rise && !timeout)
			|=> SSI_DATA == frame_reg[LAST_BIT - $past(bit_cnt_reg)];
	endproperty
	a_bit_out: assert property (p_bit_out) else $error("wrong bit on data line");

	property p_header;
		@(posedge CORE_CLK) disable iff (RST)
		start_frame |=> frame_reg[`SSIAR_HDR_POS +: `SSIAR_HDR_W] == `SSIAR_HDR_VAL;
	endproperty
	a_header: assert property (p_header) else $error("opening bits wrong");

	property p_angle;
		@(posedge CORE_CLK) disable iff (RST)
		start_frame |=> frame_reg[`SSIAR_ANGLE_POS +: `SSIAR_ANGLE_W] == $past(angle_rep);
	endproperty
	a_angle: assert property (p_angle) else $error("angle field not latched");

	property p_tail;
		@(posedge CORE_CLK) disable iff (RST)
		start_frame |=> frame_reg[`SSIAR_RSV_POS +: `SSIAR_RSV_W] == `SSIAR_RSV_VAL
			&& frame_reg[`SSIAR_CRC_POS +: `SSIAR_CRC_W] == crc_calc({$past(angle_rep), `SSIAR_RSV_VAL});
	endproperty
	a_tail: assert property (p_tail) else $error("reserved or check bits wrong");

	property p_timeout_full;
		@(posedge CORE_CLK) disable iff (RST)
		(state_reg == ssiar_pkg::SSIAR_WAIT && !clk_edge) [*1] ##0 (tmo_cnt_reg == TMO_LAST)
			|=> state_reg == ssiar_pkg::SSIAR_IDLE && SSI_DATA && !FRAME_ACTIVE;
	endproperty
	a_timeout_full: assert property (p_timeout_full) else $error("timeout did not end frame");

	property p_timer_bound;
		@(posedge CORE_CLK) disable iff (RST)
		state_reg != ssiar_pkg::SSIAR_IDLE |-> tmo_cnt_reg <= TMO_LAST;
	endproperty
	a_timer_bound: assert property (p_timer_bound) else $error("idle timer overran");

	property p_timeout_short;
		@(posedge CORE_CLK) disable iff (RST)
		(state_reg == ssiar_pkg::SSIAR_SHIFT && bit_cnt_reg == SHORT_END && timeout)
			|=> state_reg == ssiar_pkg::SSIAR_IDLE ##1 SSI_DATA;
	endproperty
	a_timeout_short: assert property (p_timeout_short) else $error("short frame not ended");

	property p_direction;
		@(posedge CORE_CLK) disable iff (RST)
		(start_frame && !ANGLE_INVERT) |=> frame_reg[`SSIAR_ANGLE_POS +: `SSIAR_ANGLE_W] == $past(ANGLE);
	endproperty
	a_direction: assert property (p_direction) else $error("angle sense reversed");

	property p_idle_line;
		@(posedge CORE_CLK) disable iff (RST)
		(state_reg == ssiar_pkg::SSIAR_IDLE && !start_frame) [*2] |-> SSI_DATA && !FRAME_ACTIVE;
	endproperty
	a_idle_line: assert property (p_idle_line) else $error("line not idle");

	c_full_frame: cover property (@(posedge CORE_CLK) disable iff (RST)
		state_reg == ssiar_pkg::SSIAR_WAIT ##1 state_reg == ssiar_pkg::SSIAR_IDLE);
	c_short_frame: cover property (@(posedge CORE_CLK) disable iff (RST)
		state_reg == ssiar_pkg::SSIAR_SHIFT && bit_cnt_reg == SHORT_END && timeout);
	c_back_to_back: cover property (@(posedge CORE_CLK) disable iff (RST)
		timeout ##[1:20] start_frame);

endmodule

// *** src/ssiar_defs.svh ***
`ifndef SSIAR_DEFS_SVH
`define SSIAR_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SSIAR_CLK_PERIOD_NS 50
`define SSIAR_TIMEOUT_NS 16000
`define SSIAR_TIMEOUT_CYC ((`SSIAR_TIMEOUT_NS + `SSIAR_CLK_PERIOD_NS - 1) / `SSIAR_CLK_PERIOD_NS)

// ----------------------------------------
// frame layout, first bit sent is the msb
// ----------------------------------------
`define SSIAR_ANGLE_W 12
`define SSIAR_RSV_W 2
`define SSIAR_CRC_W 6
`define SSIAR_HDR_W 3
`define SSIAR_FRAME_W 23
`define SSIAR_HDR_POS 20
`define SSIAR_ANGLE_POS 8
`define SSIAR_RSV_POS 6
`define SSIAR_CRC_POS 0

// ----------------------------------------
// fixed values
// ----------------------------------------
`define SSIAR_HDR_VAL 3'h2
`define SSIAR_RSV_VAL 2'h0
`define SSIAR_CRC_POLY_RST 6'h03
`define SSIAR_CRC_INIT 6'h00
`define SSIAR_IDLE_LEVEL 1'h1

`endif

// *** src/ssiar_pkg.sv ***
package ssiar_pkg;

	typedef enum logic [2:0] {
		SSIAR_IDLE = 3'h1,
		SSIAR_SHIFT = 3'h2,
		SSIAR_WAIT = 3'h4
	} ssiar_state_t;

endpackage

// *** src/ssiar_shift.sv ***
`timescale 1ns/1ps
`include "ssiar_defs.svh"

module ssiar_shift #(
	parameter int WIDTH = `SSIAR_FRAME_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [WIDTH-1:0] word,
	input wire logic shift,
	input wire logic clear,
	output logic dout
);

	logic [WIDTH-1:0] sreg_reg;

	// ----------------------------------------
	// word store, zero fill behind the last bit
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sreg_reg <= '0;
		end else if (load) begin
			sreg_reg <= word;
		end else if (shift) begin
			sreg_reg <= {sreg_reg[WIDTH-2:0], 1'h0};
		end
	end

	// ----------------------------------------
	// line driver
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout <= `SSIAR_IDLE_LEVEL;
		end else if (clear) begin
			dout <= `SSIAR_IDLE_LEVEL;
		end else if (shift) begin
			dout <= sreg_reg[WIDTH-1];
		end
	end

endmodule

// *** verif/ssiar_ctrl_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// controller model, serial master
// ----------------------------------------
module ssiar_ctrl_model #(
	parameter int HALF_NS = 200
) (
	output logic ssi_clk,
	input wire logic ssi_data
);
	// clock stands high outside frames
	initial ssi_clk = 1'h1;

	task automatic read_frame(input int nbits, input int stall_at, input int stall_ns, output logic [22:0] bits);
		bits = '0;
		ssi_clk = 1'h0;
		#(HALF_NS);
		for (int i = 0; i < nbits; i++) begin
			ssi_clk = 1'h1;
			#(HALF_NS);
			ssi_clk = 1'h0;
			if (i == stall_at) begin
				#(stall_ns);
			end
			// sample just before the next rise
			#(HALF_NS - 1);
			bits[22 - i] = ssi_data;
			#1;
		end
		ssi_clk = 1'h1;
	endtask
endmodule

// *** verif/ssi_absolute_angle_readout_bench.sv ***
`timescale 1ns/1ps
`include "ssiar_defs.svh"

module ssi_absolute_angle_readout_bench;
	localparam int TO_CYC = `SSIAR_TIMEOUT_NS / `SSIAR_CLK_PERIOD_NS;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic ssi_clk;
	logic [`SSIAR_ANGLE_W-1:0] angle = '0;
	logic ssi_data;
	logic frame_active;
	logic [15:0] lfsr_reg = 16'h4288;
	logic [22:0] got;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #25 core_clk = ~core_clk;

	ssiar_top uut (
		.CORE_CLK(core_clk),
		.RST(rst),
		.SSI_CLK(ssi_clk),
		.ANGLE(angle),
		.SSI_DATA(ssi_data),
		.FRAME_ACTIVE(frame_active)
	);

	ssiar_ctrl_model ctrl (
		.ssi_clk(ssi_clk),
		.ssi_data(ssi_data)
	);

	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic logic [15:0] lfsr_step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [22:0] expect_frame(input logic [11:0] a);
		logic [13:0] d;
		logic [5:0] c;
		logic fb;
		d = {a, 2'h0};
		c = 6'h00;
		for (int i = 13; i >= 0; i--) begin
			fb = c[5] ^ d[i];
			c = {c[4:0], 1'h0} ^ (fb ? 6'h03 : 6'h00);
		end
		return {3'h2, a, 2'h0, c};
	endfunction

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input string what, input logic [22:0] exp, input logic [22:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// one transfer plus timeout
	// ----------------------------------------
	task automatic frame(input logic [11:0] a, input int nbits, input int stall_at, input int stall_ns);
		logic [22:0] mask;
		@(posedge core_clk);
		angle <= a;
		@(posedge core_clk);
		// link edges kept off the core clock edge
		#10;
		ctrl.read_frame(nbits, stall_at, stall_ns, got);
		mask = ~(23'h7FFFFF >> nbits);
		check("frame bits", expect_frame(a) & mask, got & mask);
		repeat (TO_CYC) @(posedge core_clk);
		check("active before timeout", 23'h000001, {22'h0, frame_active});
		repeat (6) @(posedge core_clk);
		check("idle after timeout", 23'h000002, {21'h0, ssi_data, frame_active});
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		check("reset outputs", 23'h000002, {21'h0, ssi_data, frame_active});
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		frame(12'h000, 23, -1, 0);
		frame(12'h001, 23, -1, 0);
		frame(12'hFFF, 23, 5, 1000);
		frame(12'h800, 15, -1, 0);
		for (int i = 0; i < 8; i++) begin
			lfsr_reg = lfsr_step(lfsr_reg);
			frame(lfsr_reg[11:0], (lfsr_reg[15] ? 15 : 23), int'(lfsr_reg[14:12]), 400);
		end
		tally_and_finish();
	end
endmodule
